// ---- i2c_nvp_device.sv ----
// Slave end of the two-wire settings port with deferred nv write.
// Assumes link_clk runs free and well above SCL; rst is on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module i2c_nvp_device #(
  parameter int NV_WRITE_CYC = i2c_nvp_pkg::NV_WRITE_CYC
) (
  // Clocks and reset
  input  wire logic       link_clk,
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Two-wire link
  i2c_link_if.dev         link,
  // Settings seen by the rest of the chip, on ref_clk
  output logic      [7:0] wiper,
  output logic      [7:0] initial_value_setting,
  output logic      [7:0] step_ctrl,
  output logic      [7:0] control_byte,
  output logic            nv_busy,
  output logic            nv_write_pulse
);

  // -------------------------------------------------------
  // Link domain declarations
  // -------------------------------------------------------
  logic                     lrst_m, lrst_q;
  logic                     scl_m, scl_s, scl_p;
  logic                     sda_m, sda_s, sda_p;
  logic                     busy_m, busy_s;
  logic                     start_ev, stop_ev, rise, fall;
  i2c_nvp_pkg::link_state_t state_q;
  logic               [3:0] bit_cnt_q;
  logic               [7:0] shift_q;
  logic               [1:0] phase_q;
  logic                     rd_q;
  logic                     oe_q;
  logic               [7:0] addr_q;
  logic               [7:0] wiper_l, init_l, step_l, ctrl_l;
  logic                     nv_pend_q, nv_tgl_q, upd_tgl_q;
  logic                     byte_done, wr_ev, load_ev, match;
  logic               [7:0] rdata;

  // Register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] a,
                                          input logic [7:0] w,
                                          input logic [7:0] s,
                                          input logic [7:0] c);
    unique case (a)
      i2c_nvp_pkg::REG_WIPER: reg_read = w;
      i2c_nvp_pkg::REG_STEP:  reg_read = s;
      i2c_nvp_pkg::REG_CTRL:  reg_read = c;
      default:                reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Reset and pin synchronisers
  always_ff @(posedge link_clk)
  begin
    lrst_m <= rst;
    lrst_q <= lrst_m;
    scl_m  <= link.scl;
    scl_s  <= scl_m;
    scl_p  <= scl_s;
    sda_m  <= link.sda;
    sda_s  <= sda_m;
    sda_p  <= sda_s;
    busy_m <= nv_busy;
    busy_s <= busy_m;
  end

  // -------------------------------------------------------
  // Bus events
  // -------------------------------------------------------
  // start detect
  assign start_ev  = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev   = scl_s & scl_p & ~sda_p & sda_s;
  assign rise      = scl_s & ~scl_p;
  assign fall      = ~scl_s & scl_p;
  assign byte_done = (state_q == i2c_nvp_pkg::LS_RECV) && fall
                     && (bit_cnt_q == 4'h8);
  assign match     = (shift_q[7:1] == i2c_nvp_pkg::DEV_ADDR) && !busy_s;
  assign wr_ev     = byte_done && (phase_q == 2'h2);
  assign load_ev   = fall && rd_q && ((state_q == i2c_nvp_pkg::LS_ACK)
                     || (state_q == i2c_nvp_pkg::LS_MACK));
  assign rdata     = reg_read(addr_q, wiper_l, step_l, ctrl_l);
  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = oe_q;

  // -------------------------------------------------------
  // Byte engine
  // -------------------------------------------------------
  // Bit and byte sequencing on SCL edges
  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      state_q   <= i2c_nvp_pkg::LS_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      phase_q   <= 2'h0;
      rd_q      <= 1'b0;
      oe_q      <= 1'b0;
    end
    else if (start_ev)
    begin
      state_q   <= i2c_nvp_pkg::LS_RECV;
      bit_cnt_q <= 4'h0;
      phase_q   <= 2'h0;
      rd_q      <= 1'b0;
      oe_q      <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_q <= i2c_nvp_pkg::LS_IDLE;
      oe_q    <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        i2c_nvp_pkg::LS_IDLE: ;
        i2c_nvp_pkg::LS_RECV:
        begin
          if (rise)
          begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            if (phase_q == 2'h0 && !match)
              state_q <= i2c_nvp_pkg::LS_IDLE;
            else
            begin
              oe_q    <= 1'b1;
              state_q <= i2c_nvp_pkg::LS_ACK;
              if (phase_q == 2'h0)
                rd_q <= shift_q[0];
              if (phase_q != 2'h2)
                phase_q <= phase_q + 2'h1;
            end
          end
        end
        i2c_nvp_pkg::LS_ACK:
          if (fall)
          begin
            bit_cnt_q <= 4'h0;
            if (rd_q)
            begin
              shift_q <= rdata;
              oe_q    <= ~rdata[7];
              state_q <= i2c_nvp_pkg::LS_SEND;
            end
            else
            begin
              oe_q    <= 1'b0;
              state_q <= i2c_nvp_pkg::LS_RECV;
            end
          end
        i2c_nvp_pkg::LS_SEND:
          if (fall)
          begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7)
            begin
              oe_q    <= 1'b0;
              state_q <= i2c_nvp_pkg::LS_MACK;
            end
            else
            begin
              shift_q <= {shift_q[6:0], 1'b0};
              oe_q    <= ~shift_q[6];
            end
          end
        i2c_nvp_pkg::LS_MACK:
          if (rise && sda_s)
            state_q <= i2c_nvp_pkg::LS_IDLE;
          else if (fall)
          begin
            shift_q   <= rdata;
            oe_q      <= ~rdata[7];
            bit_cnt_q <= 4'h0;
            state_q   <= i2c_nvp_pkg::LS_SEND;
          end
        default:
          state_q <= i2c_nvp_pkg::LS_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------
  // Address counter and settings
  // -------------------------------------------------------
  // Counter load and advance
  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      addr_q <= 8'h00;
    else if (byte_done && phase_q == 2'h1)
      addr_q <= shift_q;
    else if (wr_ev || load_ev)
      addr_q <= addr_q + 8'h01;
  end

  // Settings update at data ack
  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      wiper_l   <= i2c_nvp_pkg::WIPER_RST;
      init_l    <= i2c_nvp_pkg::INIT_RST;
      step_l    <= i2c_nvp_pkg::STEP_RST;
      ctrl_l    <= i2c_nvp_pkg::CTRL_RST;
      upd_tgl_q <= 1'b0;
    end
    else if (wr_ev)
    begin
      upd_tgl_q <= ~upd_tgl_q;
      unique case (addr_q)
        i2c_nvp_pkg::REG_WIPER:
        begin
          wiper_l <= shift_q;
          if (!ctrl_l[i2c_nvp_pkg::CTRL_WONLY])
            init_l <= shift_q;
        end
        i2c_nvp_pkg::REG_STEP: step_l <= shift_q;
        i2c_nvp_pkg::REG_CTRL: ctrl_l <= shift_q;
        default: ;
      endcase
    end
  end

  // Pending nv write, issued at stop
  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      nv_pend_q <= 1'b0;
      nv_tgl_q  <= 1'b0;
    end
    else if (start_ev)
      nv_pend_q <= 1'b0;
    else if (stop_ev)
    begin
      nv_pend_q <= 1'b0;
      if (nv_pend_q)
        nv_tgl_q <= ~nv_tgl_q;
    end
    else if (wr_ev && !(addr_q == i2c_nvp_pkg::REG_WIPER
                        && ctrl_l == i2c_nvp_pkg::CTRL_NO_NV))
      nv_pend_q <= 1'b1;
  end

  // -------------------------------------------------------
  // Reference clock side
  // -------------------------------------------------------
  logic        nvt_m, nvt_s, nvt_p;
  logic        upd_m, upd_s, upd_p;
  logic [31:0] nv_cnt_q;

  // Toggle synchronisers from the link domain
  always_ff @(posedge ref_clk)
  begin
    nvt_m <= nv_tgl_q;
    nvt_s <= nvt_m;
    nvt_p <= nvt_s;
    upd_m <= upd_tgl_q;
    upd_s <= upd_m;
    upd_p <= upd_s;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      nv_cnt_q       <= 32'h0;
      nv_busy        <= 1'b0;
      nv_write_pulse <= 1'b0;
    end
    else
    begin
      nv_write_pulse <= nvt_s ^ nvt_p;
      if (nvt_s ^ nvt_p)
      begin
        nv_cnt_q <= 32'(NV_WRITE_CYC);
        nv_busy  <= 1'b1;
      end
      else if (nv_cnt_q != 32'h0)
      begin
        nv_cnt_q <= nv_cnt_q - 32'h1;
        nv_busy  <= (nv_cnt_q != 32'h1);
      end
    end
  end

  // Settings copy; link values stay stable many cycles after a toggle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wiper                 <= i2c_nvp_pkg::WIPER_RST;
      initial_value_setting <= i2c_nvp_pkg::INIT_RST;
      step_ctrl             <= i2c_nvp_pkg::STEP_RST;
      control_byte          <= i2c_nvp_pkg::CTRL_RST;
    end
    else if (upd_s ^ upd_p)
    begin
      wiper                 <= wiper_l;
      initial_value_setting <= init_l;
      step_ctrl             <= step_l;
      control_byte          <= ctrl_l;
    end
  end

endmodule : i2c_nvp_device

`default_nettype wire

// ---- i2c_nvp_pkg.sv ----
// Shared constants and types for the two-wire settings port.
// Assumes both ends and the testbench refer to names here.
package i2c_nvp_pkg;

  // ---------------------------------------------------------
  // Bus addressing
  // ---------------------------------------------------------
  localparam logic [6:0] DEV_ADDR   = 7'h28; // Address byte 50h
  localparam logic [7:0] REG_WIPER  = 8'h00;
  localparam logic [7:0] REG_STEP   = 8'h01;
  localparam logic [7:0] REG_CTRL   = 8'h02;
  localparam int         CTRL_WONLY = 7;     // Wiper-only write bit
  localparam logic [7:0] CTRL_NO_NV = 8'h80;

  // ---------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------
  localparam logic [7:0] WIPER_RST  = 8'h00;
  localparam logic [7:0] INIT_RST   = 8'h00;
  localparam logic [7:0] STEP_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  // ---------------------------------------------------------
  // Timing
  // ---------------------------------------------------------
  localparam int REF_CLK_PS   = 5000;
  localparam int SCL_QTR_NS   = 625;        // Quarter of a 400 kHz bit
  localparam int SCL_QTR_CYC  = (SCL_QTR_NS * 1000) / REF_CLK_PS;
  localparam int NV_WRITE_NS  = 10000000;   // nv_write_cycle_time
  localparam int NV_WRITE_CYC = (NV_WRITE_NS / REF_CLK_PS) * 1000;

  // ---------------------------------------------------------
  // State types
  // ---------------------------------------------------------
  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_RECV = 3'b001,
    LS_ACK  = 3'b010,
    LS_SEND = 3'b011,
    LS_MACK = 3'b100
  } link_state_t;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WBYTE = 2'b01,
    OP_RBYTE = 2'b10,
    OP_STOP  = 2'b11
  } host_op_t;

endpackage : i2c_nvp_pkg

// ---- i2c_link_if.sv ----
// Two-wire link between bus master and settings port.
// Assumes open-drain SDA: an enabled driver with output 0 pulls low.
`timescale 1ns/1ps
`default_nettype none

interface i2c_link_if;
  logic scl;       // Push-pull clock from the master
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  wire  sda;

  // Wired-AND of both open-drain drivers with pull-up
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
  modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface : i2c_link_if

`default_nettype wire

// ---- i2c_nvp_host.sv ----
// Bus master end: one register write or read per command.
// Assumes ref_clk at 200 MHz; SCL is divided from it and driven out.
`timescale 1ns/1ps
`default_nettype none

module i2c_nvp_host (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Two-wire link
  i2c_link_if.host        link,
  // Command port
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_data,
  // Answer port
  output logic            rsp_valid,
  output logic      [7:0] rsp_data,
  output logic            rsp_nack
);

  logic                  run_q, scl_q, oe_q, sm, ss;
  logic            [7:0] qcnt_q, reg_q, dat_q, rx_q;
  logic            [2:0] step_q;
  logic            [1:0] ph_q;
  logic            [3:0] bit_q;
  logic                  rd_q, nack_q, retry_q, tick;
  i2c_nvp_pkg::host_op_t op;
  logic            [7:0] tx;

  // Operation at each step of a command
  function automatic i2c_nvp_pkg::host_op_t op_of(input logic rd,
                                                  input logic [2:0] s);
    unique case (s)
      3'h0:    op_of = i2c_nvp_pkg::OP_START;
      3'h3:    op_of = rd ? i2c_nvp_pkg::OP_START : i2c_nvp_pkg::OP_WBYTE;
      3'h4:    op_of = rd ? i2c_nvp_pkg::OP_WBYTE : i2c_nvp_pkg::OP_STOP;
      3'h5:    op_of = i2c_nvp_pkg::OP_RBYTE;
      3'h6:    op_of = i2c_nvp_pkg::OP_STOP;
      default: op_of = i2c_nvp_pkg::OP_WBYTE;
    endcase
  endfunction : op_of

  assign op        = op_of(rd_q, step_q);
  assign tx        = (step_q == 3'h1) ? {i2c_nvp_pkg::DEV_ADDR, 1'b0} :
                     (step_q == 3'h2) ? reg_q :
                     (step_q == 3'h4) ? {i2c_nvp_pkg::DEV_ADDR, 1'b1} :
                     dat_q;
  assign tick      = run_q && (qcnt_q == 8'(i2c_nvp_pkg::SCL_QTR_CYC - 1));
  assign cmd_ready = !run_q;
  assign link.scl      = scl_q;
  assign link.sda_h_o  = 1'b0;
  assign link.sda_h_oe = oe_q;

  // SDA synchroniser and quarter-bit divider
  always_ff @(posedge ref_clk)
  begin
    sm <= link.sda;
    ss <= sm;
    if (rst || tick || !run_q)
      qcnt_q <= 8'h00;
    else
      qcnt_q <= qcnt_q + 8'h01;
  end

  // Command sequencer and line drive
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      run_q <= 1'b0; scl_q <= 1'b1; oe_q <= 1'b0;
      step_q <= 3'h0; ph_q <= 2'h0; bit_q <= 4'h0;
      rd_q <= 1'b0; reg_q <= 8'h00; dat_q <= 8'h00; rx_q <= 8'h00;
      nack_q <= 1'b0; retry_q <= 1'b0;
      rsp_valid <= 1'b0; rsp_data <= 8'h00; rsp_nack <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (!run_q && cmd_valid)
      begin
        run_q <= 1'b1; rd_q <= cmd_read; reg_q <= cmd_reg;
        dat_q <= cmd_data; step_q <= 3'h0; ph_q <= 2'h0;
        bit_q <= 4'h0; rsp_nack <= 1'b0; retry_q <= 1'b0;
      end
      else if (tick)
      begin
        ph_q <= ph_q + 2'h1;
        unique case (op)
          i2c_nvp_pkg::OP_START:
            unique case (ph_q)
              2'h0: begin scl_q <= 1'b0; oe_q <= 1'b0; end
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q <= 1'b1;
              2'h3: begin scl_q <= 1'b0; step_q <= step_q + 3'h1; end
            endcase
          i2c_nvp_pkg::OP_STOP:
            unique case (ph_q)
              2'h0: begin scl_q <= 1'b0; oe_q <= 1'b1; end
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q <= 1'b0;
              2'h3:
              if (retry_q)
              begin
                retry_q <= 1'b0;
                step_q  <= 3'h0;
              end
              else
              begin
                run_q     <= 1'b0;
                rsp_valid <= 1'b1;
                rsp_data  <= rx_q;
              end
            endcase
          default:
            unique case (ph_q)
              // MSB first out; nack the read byte
              2'h0: oe_q <= (op == i2c_nvp_pkg::OP_WBYTE) && bit_q < 4'h8
                            && !tx[3'h7 - bit_q[2:0]];
              2'h1: scl_q <= 1'b1;
              2'h2:
                if (bit_q < 4'h8)
                  rx_q <= {rx_q[6:0], ss};
                else
                  nack_q <= (op == i2c_nvp_pkg::OP_WBYTE) && ss;
              2'h3:
              begin
                scl_q <= 1'b0;
                bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
                if (bit_q == 4'h8)
                begin
                  if (nack_q)
                  begin
                    step_q <= rd_q ? 3'h6 : 3'h4;
                    if (step_q == 3'h1 || step_q == 3'h4)
                      retry_q <= 1'b1;
                    else
                      rsp_nack <= 1'b1;
                  end
                  else
                    step_q <= step_q + 3'h1;
                end
              end
            endcase
        endcase
      end
    end
  end

endmodule : i2c_nvp_host

`default_nettype wire

// ---- i2c_slave_nv_register_port_assertions.sv ----
// Concurrent checks on the two-wire link joining both ends.
// Assumes it sits beside the link interface and sees its signals.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_nv_register_port_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe
);
  // ---------------------------------------------------------
  // Bus position tracking
  // ---------------------------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_q;
  logic [1:0] byt_q;
  logic       rd_q;
  logic       start_c;
  logic       stop_c;
  logic       rise_c;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Bus conditions seen on the sampled lines
  assign start_c = scl & scl_q & sda_q & ~sda;
  assign stop_c  = scl & scl_q & ~sda_q & sda;
  assign rise_c  = scl & ~scl_q;

  // Previous line levels
  always_ff @(posedge ref_clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // Bit and byte position since the last start
  always_ff @(posedge ref_clk)
  begin
    if (rst | start_c)
    begin
      bit_q <= 4'h0;
      byt_q <= 2'h0;
    end
    else if (rise_c)
    begin
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      if (bit_q == 4'h8 && byt_q != 2'h3)
      begin
        byt_q <= byt_q + 2'h1;
      end
    end
  end

  // Direction bit of the address byte
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_q <= 1'b0;
    end
    else if (rise_c && byt_q == 2'h0 && bit_q == 4'h7)
    begin
      rd_q <= sda;
    end
  end

  // ---------------------------------------------------------
  // Properties
  // ---------------------------------------------------------
  property p_start_host;
    start_c |-> sda_h_oe && !sda_d_oe;
  endproperty
  a_start_host: assert property (p_start_host)
    else $error("start not made by the master");

  property p_stop_free;
    stop_c |=> !sda_d_oe [*8];
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("device drives data after stop");

  property p_dev_low;
    $changed(sda_d_oe) |-> !scl;
  endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device data changed with clock high");

  property p_dev_hold;
    rise_c |=> $stable(sda_d_oe) [*8];
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("device data not held after clock rise");

  property p_addr_quiet;
    rise_c && byt_q == 2'h0 && bit_q != 4'h8 |-> !sda_d_oe;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("device drives during address bits");

  property p_wr_ack;
    rise_c && !rd_q && byt_q != 2'h0 && bit_q == 4'h8
      |-> sda_d_oe && !sda_h_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged by device");

  property p_rd_host_off;
    rise_c && rd_q && byt_q == 2'h1 && bit_q != 4'h8 |-> !sda_h_oe;
  endproperty
  a_rd_host_off: assert property (p_rd_host_off)
    else $error("master drives during read data bits");

  property p_rd_nack;
    rise_c && rd_q && byt_q == 2'h1 && bit_q == 4'h8 |-> sda && !sda_d_oe;
  endproperty
  a_rd_nack: assert property (p_rd_nack)
    else $error("last read byte not answered with nack");

  // Main scenarios reached
  c_start: cover property (start_c);
  c_stop: cover property (stop_c);
  c_rd_nack: cover property (rise_c && rd_q && byt_q == 2'h1 && bit_q == 4'h8);
endmodule : i2c_slave_nv_register_port_assertions

`default_nettype wire

// ---- i2c_slave_nv_register_port_tb.sv ----
// Testbench joining master and device ends across the link.
// Assumes the package, link interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_nv_register_port_tb;
  localparam int NV_CYC = 6000; // Shortened nv write time

  // ---------------------------------------------------------
  // Signals
  // ---------------------------------------------------------
  logic       ref_clk;
  logic       link_clk;
  logic       rst;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       cmd_read;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_data;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic [7:0] wiper;
  logic [7:0] initial_value_setting;
  logic [7:0] step_ctrl;
  logic [7:0] control_byte;
  logic       nv_busy;
  logic       nv_write_pulse;
  int         fails = 0;
  int         checks = 0;
  int         pulses = 0;
  int         busy_cyc = 0;
  int         took;

  // ---------------------------------------------------------
  // Design ends and checker
  // ---------------------------------------------------------
  i2c_link_if u_i2c_link_if ();
  i2c_nvp_host u_i2c_nvp_host (.ref_clk(ref_clk), .rst(rst),
    .link(u_i2c_link_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  i2c_nvp_device #(.NV_WRITE_CYC(NV_CYC)) u_i2c_nvp_device (
    .link_clk(link_clk), .ref_clk(ref_clk), .rst(rst),
    .link(u_i2c_link_if), .wiper(wiper),
    .initial_value_setting(initial_value_setting),
    .step_ctrl(step_ctrl), .control_byte(control_byte),
    .nv_busy(nv_busy), .nv_write_pulse(nv_write_pulse));
  i2c_slave_nv_register_port_assertions u_checker (.ref_clk(ref_clk),
    .rst(rst), .scl(u_i2c_link_if.scl),
    .sda(u_i2c_link_if.sda), .sda_h_oe(u_i2c_link_if.sda_h_oe),
    .sda_d_oe(u_i2c_link_if.sda_d_oe));

  // ---------------------------------------------------------
  // Clocks and monitors
  // ---------------------------------------------------------
  // Reference clock, 5 ns period
  always #2.5 ref_clk = ~ref_clk;

  // Link clock, 48 ns period, offset phase
  initial
  begin
    link_clk = 1'b0;
    #7.3;
    forever #24 link_clk = ~link_clk;
  end

  // Count nv write starts and busy cycles
  always @(posedge ref_clk)
  begin
    if (nv_write_pulse === 1'b1) pulses <= pulses + 1;
    if (nv_busy === 1'b1) busy_cyc <= busy_cyc + 1;
  end

  // ---------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------
  // One command through the master, waits for its answer
  task automatic run_cmd(input logic rd, input logic [7:0] rg,
                         input logic [7:0] dt);
    @(posedge ref_clk);
    #1;
    while (cmd_ready !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_reg   = rg;
    cmd_data  = dt;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    took = 0;
    while (rsp_valid !== 1'b1 && took < 60000)
    begin
      @(posedge ref_clk);
      #1;
      took++;
    end
    // A command that never answers counts against the run
    if (took >= 60000)
    begin
      fails++;
      $display("mismatch rsp_valid expected 1 seen 0");
    end
  endtask : run_cmd

  // Compare one value
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Verdict and end of run
  task end_sim;
    if (fails == 0 && checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------
  // Tests
  // ---------------------------------------------------------
  initial
  begin
    ref_clk   = 1'b0;
    rst       = 1'b1;
    cmd_valid = 1'b0;
    cmd_read  = 1'b0;
    cmd_reg   = 8'h00;
    cmd_data  = 8'h00;
    repeat (8) @(posedge link_clk);
    @(posedge ref_clk);
    #1;
    rst = 1'b0;
    run_cmd(1'b0, i2c_nvp_pkg::REG_STEP, 8'h5a);
    chk("nack", 8'h00, {7'h00, rsp_nack});
    chk("step", 8'h5a, step_ctrl);
    run_cmd(1'b1, i2c_nvp_pkg::REG_STEP, 8'h00);
    chk("rdata", 8'h5a, rsp_data);
    chk("retry", 8'h01, {7'h00, took > 20500});
    chk("pulses", 8'h01, pulses[7:0]);
    run_cmd(1'b0, i2c_nvp_pkg::REG_CTRL, i2c_nvp_pkg::CTRL_NO_NV);
    chk("ctrl", 8'h80, control_byte);
    run_cmd(1'b0, i2c_nvp_pkg::REG_WIPER, 8'h3c);
    chk("wiper", 8'h3c, wiper);
    chk("initial", 8'h00, initial_value_setting);
    run_cmd(1'b1, i2c_nvp_pkg::REG_WIPER, 8'h00);
    chk("rwiper", 8'h3c, rsp_data);
    chk("noretry", 8'h00, {7'h00, took > 20500});
    chk("pulses2", 8'h02, pulses[7:0]);
    chk("busy", 8'h01, {7'h00, busy_cyc == 2 * NV_CYC});
    chk("step2", 8'h5a, step_ctrl);
    end_sim();
  end

  // Watchdog on a hung run; a clean run needs about 94000 cycles
  initial
  begin
    repeat (105000) @(posedge ref_clk);
    fails = fails + 1;
    end_sim();
  end
endmodule : i2c_slave_nv_register_port_tb

`default_nettype wire
